// *** core/ipv_top.sv ***
// Interrupt prioritizer and vectoring logic with classic Wishbone register access
//
// What this block does
// R01 - System control bit 4 selects structure-2 mode 0 or mode 1.
// R02 - System control bit 2 reads one; bits 1, 3, 7..5 read zero.
// R03 - Vectors: non-maskable 0073h, node 0 at 0003h, eight bytes apart.
// R04 - Enable low bits 0..5 enable nodes 0..5; bit 6 reads zero.
// R05 - Enable high bits 0..7 enable nodes 6..13 in ascending order.
// R06 - Global mask bit 7 low blocks all maskable requests, never the non-maskable.
// R07 - Reset clears every node enable and every non-maskable source enable.
// R08 - Five non-maskable sources share one vector, each with its own enable.
// R09 - Only a strictly higher level pre-empts a routine in service.
// R10 - Highest level wins; ties go by polling order, non-maskable first.
// R11 - Requests sampled at phase 2, evaluated during the next machine cycle.
// R12 - No call while equal level serves, mid-instruction, or return/enable/priority write.
// R13 - After return or enable/priority write, one more instruction runs first.
// R14 - Blocked or vanished requests are not remembered between polls.
// R15 - Acknowledge makes the core do a long call to the vector address.
// R16 - Return-from-interrupt releases the level in service.
// R17 - Plain subroutine return leaves the in-service level active.
// R18 - Call takes two machine cycles; three cycles least to first instruction.
// R19 - Waiting for an instruction's last cycle adds at most three cycles.
// R20 - Single interrupt response lies between three and under nine cycles.
// R21 - Software changes the mode bit by read-modify-write only.
// R22 - Mode 1 latches enabled events regardless of node enable; mode 0 needs it.
// R23 - Acknowledge clears the latched pending request; status flags stay.
// R24 - Mode 0 clearing node enable clears pending; mode 1 clearing flags does.
// R25 - Global mask only hides pending requests; capture continues.
// R26 - One request with vector offered to core; acknowledge names serviced node.
// R27 - In-service stack of four levels plus non-maskable; return frees highest.
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`include "ipv_defines.svh"

module ipv_top import ipv_pkg::*; (
    // Clock, reset and clock enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Interrupt sources
    input wire logic [13:0] node_event_i,
    input wire logic [13:0] node_flags_i,
    input wire logic [4:0] nm_event_i,
    input wire logic [4:0] nm_flags_i,
    // Core timing
    input wire logic mc_phase2_i,
    input wire logic last_cycle_i,
    input wire logic return_from_interrupt_i,
    // Call handshake with the core
    output logic call_req_o,
    output logic [15:0] call_vec_o,
    output logic [3:0] call_rank_o,
    input wire logic call_ack_i,
    input wire logic [3:0] ack_rank_i,
    // Mode outputs
    output logic struct2_mode_o,
    output logic sfr_page_select_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Level of a polling rank: 5 for non-maskable, else priority plus one
    function automatic logic [2:0] rank_level(input logic [3:0] rank, input logic [13:0] lo,
                                              input logic [13:0] hi);
        logic [3:0] n;
        n = rank - 4'h1;
        if (rank == 4'h0) begin
            rank_level = `IPV_LEVEL_NMI; // [R10]
        end else begin
            rank_level = {1'b0, hi[n], lo[n]} + 3'h1;
        end
    endfunction : rank_level

    function automatic logic [15:0] rank_vector(input logic [3:0] rank);
        if (rank == 4'h0) begin
            rank_vector = `IPV_VEC_NMI; // [R03]
        end else begin
            rank_vector = `IPV_VEC_BASE + {9'h000, rank - 4'h1, 3'h0}; // [R03]
        end
    endfunction : rank_vector

    ////////////////////////////////////////////////////////////////////////////
    // State

    ipv_state_t state_reg;
    ipv_state_t state_next;

    logic [13:0] node_en;
    logic [13:0] prio_lo;
    logic [13:0] prio_hi;
    logic [14:0] ena;
    logic [14:0] flags_any;
    logic [14:0] event_in;
    logic [14:0] req_raw;
    logic [2:0] cur_lvl;
    logic [2:0] best_lvl;
    logic [3:0] best_rank;
    logic [2:0] lvl_i;
    logic found;
    logic bus_req;
    logic bus_wr;
    logic ctrl_wr;
    logic end_of_instr;
    logic [7:0] rd_byte;

    assign node_en = {state_reg.en_high, state_reg.en_low}; // [R04] [R05]
    assign prio_lo = {state_reg.pr_lo1, state_reg.pr_lo0};
    assign prio_hi = {state_reg.pr_hi1, state_reg.pr_hi0};
    assign ena = {node_en, |state_reg.nm_en};
    assign flags_any = {node_flags_i, |nm_flags_i};
    assign event_in = {node_event_i, |(nm_event_i & state_reg.nm_en)}; // [R08]
    assign bus_req = cyc_i & stb_i & ~state_reg.wb_ack;
    assign bus_wr = bus_req & we_i & sel_i[0];
    assign end_of_instr = mc_phase2_i & last_cycle_i;

    // Writes to node enable or priority registers delay vectoring
    assign ctrl_wr = bus_wr & (adr_i == `IPV_OFF_EN_LOW || adr_i == `IPV_OFF_EN_HIGH ||
                               adr_i == `IPV_OFF_PRIO_LOW_0 || adr_i == `IPV_OFF_PRIO_HIGH_0 ||
                               adr_i == `IPV_OFF_PRIO_LOW_1 || adr_i == `IPV_OFF_PRIO_HIGH_1);

    ////////////////////////////////////////////////////////////////////////////
    // Request to core: maskable nodes need node enable and global mask

    always_comb begin
        req_raw = state_reg.pend;
        req_raw[0] = state_reg.pend[0]; // [R06]
        req_raw[14:1] = state_reg.pend[14:1] & node_en & {14{state_reg.mask}}; // [R06] [R25]
    end

    // Current in-service level, 0 when idle
    always_comb begin
        cur_lvl = 3'h0;
        for (int i = 0; i < 5; i++) begin
            if (state_reg.isr[i]) begin
                cur_lvl = 3'(i + 1); // [R27]
            end
        end
    end

    // Winner among the sampled requests
    always_comb begin
        best_lvl = 3'h0;
        best_rank = 4'h0;
        found = 1'b0;
        lvl_i = 3'h0;
        for (int i = 0; i < `IPV_RANKS; i++) begin
            lvl_i = rank_level(4'(i), prio_lo, prio_hi);
            if (state_reg.smp[i] && lvl_i > best_lvl) begin // [R10]
                best_lvl = lvl_i;
                best_rank = 4'(i);
                found = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read data

    always_comb begin
        unique case (adr_i)
            `IPV_OFF_SYSCON: rd_byte = {3'h0, state_reg.mode, 1'b0, 1'b1, 1'b0, state_reg.sfr_page}; // [R02]
            `IPV_OFF_EN_LOW: rd_byte = {state_reg.mask, 1'b0, state_reg.en_low}; // [R04]
            `IPV_OFF_EN_HIGH: rd_byte = state_reg.en_high;
            `IPV_OFF_NM_EN: rd_byte = {1'b0, state_reg.nm_en[4:3], 2'h0, state_reg.nm_en[2:0]};
            `IPV_OFF_PRIO_LOW_0: rd_byte = {2'h0, state_reg.pr_lo0};
            `IPV_OFF_PRIO_HIGH_0: rd_byte = {2'h0, state_reg.pr_hi0};
            `IPV_OFF_PRIO_LOW_1: rd_byte = state_reg.pr_lo1;
            `IPV_OFF_PRIO_HIGH_1: rd_byte = state_reg.pr_hi1;
            `IPV_OFF_STATUS: rd_byte = {2'h0, state_reg.call_req, state_reg.isr};
            default: rd_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_next = state_reg;
        state_next.wb_ack = bus_req;
        state_next.wb_dat = bus_req ? rd_byte : 8'h00;

        // Register writes
        if (bus_wr) begin
            unique case (adr_i)
                `IPV_OFF_SYSCON: begin
                    state_next.mode = dat_i[`IPV_SYSCON_MODE_BIT]; // [R01]
                    state_next.sfr_page = dat_i[`IPV_SYSCON_PAGE_BIT];
                end
                `IPV_OFF_EN_LOW: begin
                    state_next.en_low = dat_i[5:0]; // [R04]
                    state_next.mask = dat_i[`IPV_EN_LOW_MASK_BIT]; // [R06]
                end
                `IPV_OFF_EN_HIGH: state_next.en_high = dat_i[7:0]; // [R05]
                `IPV_OFF_NM_EN: state_next.nm_en = {dat_i[`IPV_NM_ECC_BIT], dat_i[`IPV_NM_SUPPLY_BIT],
                                                    dat_i[`IPV_NM_FLASH_BIT], dat_i[`IPV_NM_PLL_BIT],
                                                    dat_i[`IPV_NM_WDT_BIT]}; // [R08]
                `IPV_OFF_PRIO_LOW_0: state_next.pr_lo0 = dat_i[5:0];
                `IPV_OFF_PRIO_HIGH_0: state_next.pr_hi0 = dat_i[5:0];
                `IPV_OFF_PRIO_LOW_1: state_next.pr_lo1 = dat_i[7:0];
                `IPV_OFF_PRIO_HIGH_1: state_next.pr_hi1 = dat_i[7:0];
                default: ;
            endcase
        end

        // Pending latches: clear first, set wins
        for (int i = 0; i < `IPV_RANKS; i++) begin
            if (state_reg.mode ? ~flags_any[i] : ~ena[i]) begin
                state_next.pend[i] = 1'b0; // [R24]
            end
            if (call_ack_i && ack_rank_i == 4'(i)) begin
                state_next.pend[i] = 1'b0; // [R23]
            end
            if (event_in[i] && (state_reg.mode || ena[i])) begin
                state_next.pend[i] = 1'b1; // [R22] [R25]
            end
        end

        // Acknowledge: long call under way, level enters service
        if (call_ack_i && state_reg.call_req) begin
            state_next.call_req = 1'b0; // [R15] [R26]
            state_next.isr[state_reg.call_lvl - 3'h1] = 1'b1; // [R27]
        end

        // Machine cycle phase 2: poll previous sample, then resample
        if (mc_phase2_i) begin
            state_next.smp = req_raw; // [R11] [R14]
            if (found && !state_reg.call_req && last_cycle_i && !return_from_interrupt_i && !state_reg.hold &&
                best_lvl > cur_lvl) begin // [R09] [R12] [R18] [R19] [R20]
                state_next.call_req = 1'b1; // [R26]
                state_next.call_vec = rank_vector(best_rank); // [R03]
                state_next.call_rank = best_rank;
                state_next.call_lvl = best_lvl;
            end
            if (return_from_interrupt_i && last_cycle_i && cur_lvl != 3'h0) begin
                state_next.isr[cur_lvl - 3'h1] = 1'b0; // [R16] [R17] [R27]
            end
        end

        // Hold: the instruction after a return or control write completes first
        if (end_of_instr) begin
            state_next.hold = return_from_interrupt_i; // [R13]
        end
        if (ctrl_wr) begin
            state_next.hold = 1'b1; // [R12] [R13]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0; // [R07]
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign ack_o = state_reg.wb_ack;
    assign dat_o = {24'h000000, state_reg.wb_dat};
    assign call_req_o = state_reg.call_req;
    assign call_vec_o = state_reg.call_vec;
    assign call_rank_o = state_reg.call_rank;
    assign struct2_mode_o = state_reg.mode;
    assign sfr_page_select_o = state_reg.sfr_page;

endmodule : ipv_top

// *** include/ipv_defines.svh ***
// Register offsets, field positions, reset values and vector constants of the interrupt prioritizer
`ifndef IPV_DEFINES_SVH
`define IPV_DEFINES_SVH

`define IPV_OFF_SYSCON 8'h00
`define IPV_OFF_EN_LOW 8'h04
`define IPV_OFF_EN_HIGH 8'h08
`define IPV_OFF_NM_EN 8'h0C
`define IPV_OFF_PRIO_LOW_0 8'h10
`define IPV_OFF_PRIO_HIGH_0 8'h14
`define IPV_OFF_PRIO_LOW_1 8'h18
`define IPV_OFF_PRIO_HIGH_1 8'h1C
`define IPV_OFF_STATUS 8'h20

`define IPV_SYSCON_PAGE_BIT 0
`define IPV_SYSCON_ONE_BIT 2
`define IPV_SYSCON_MODE_BIT 4
`define IPV_EN_LOW_MASK_BIT 7

`define IPV_NM_WDT_BIT 0
`define IPV_NM_PLL_BIT 1
`define IPV_NM_FLASH_BIT 2
`define IPV_NM_SUPPLY_BIT 5
`define IPV_NM_ECC_BIT 6

`define IPV_RESET_BYTE 8'h00
`define IPV_VEC_NMI 16'h0073
`define IPV_VEC_BASE 16'h0003
`define IPV_VEC_STEP 16'h0008

`define IPV_NODES 14
`define IPV_RANKS 15
`define IPV_LEVEL_NMI 3'h5

`endif

// *** include/ipv_pkg.sv ***
// Types of the interrupt prioritizer
package ipv_pkg;

    typedef struct packed {
        logic mode;
        logic sfr_page;
        logic [5:0] en_low;
        logic mask;
        logic [7:0] en_high;
        logic [4:0] nm_en;
        logic [5:0] pr_lo0;
        logic [5:0] pr_hi0;
        logic [7:0] pr_lo1;
        logic [7:0] pr_hi1;
        logic [14:0] pend;
        logic [14:0] smp;
        logic [4:0] isr;
        logic hold;
        logic call_req;
        logic [15:0] call_vec;
        logic [3:0] call_rank;
        logic [2:0] call_lvl;
        logic wb_ack;
        logic [7:0] wb_dat;
    } ipv_state_t;

endpackage : ipv_pkg

// *** sim/ipv_top_asserts.sv ***
// Port assertions for the interrupt prioritizer
`timescale 1ns/100ps
module ipv_top_asserts (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Core side
    input wire logic mc_phase2_i,
    input wire logic last_cycle_i,
    input wire logic return_from_interrupt_i,
    input wire logic call_req_o,
    input wire logic [15:0] call_vec_o,
    input wire logic [3:0] call_rank_o,
    input wire logic call_ack_i,
    input wire logic struct2_mode_o
);
    logic gap_reg;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Marks the instruction that follows a return
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_reg <= 1'b0;
        end else if (ce_i && mc_phase2_i && last_cycle_i) begin
            gap_reg <= return_from_interrupt_i;
        end
    end
    sequence s_take;
        cyc_i && stb_i && !ack_o && ce_i;
    endsequence
    sequence s_rd_sys;
        s_take ##0 (!we_i && adr_i == 8'h00) ##1 ack_o;
    endsequence
    a_ack_once:
        assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_sys_fixed:
        assert property (s_rd_sys |-> dat_o[7:5] == 3'h0 && dat_o[3:1] == 3'h2) else $error("fixed bits");
    a_mode_read:
        assert property (s_rd_sys |-> dat_o[4] == struct2_mode_o) else $error("mode bit");
    a_low_rsvd:
        assert property (s_take ##0 (!we_i && adr_i == 8'h04) ##1 ack_o |-> !dat_o[6]) else $error("bit 6");
    a_vec_map:
        assert property (call_req_o |-> call_rank_o <= 4'hE && call_vec_o == (call_rank_o == 4'h0 ? 16'h0073
            : 16'h0003 + {call_rank_o - 4'h1, 3'h0})) else $error("vector");
    a_call_poll:
        assert property ($rose(call_req_o) |-> $past(mc_phase2_i) && $past(last_cycle_i) && !$past(return_from_interrupt_i))
            else $error("call off boundary");
    a_call_hold:
        assert property (call_req_o && !call_ack_i |=> call_req_o && $stable(call_vec_o)) else $error("hold");
    a_call_done:
        assert property (call_req_o && call_ack_i && ce_i |=> !call_req_o) else $error("call kept");
    a_return_from_interrupt_gap:
        assert property (gap_reg |=> !$rose(call_req_o)) else $error("call after return");
endmodule : ipv_top_asserts

bind ipv_top ipv_top_asserts ipv_top_asserts_i (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o,
    .ack_o, .mc_phase2_i, .last_cycle_i, .return_from_interrupt_i, .call_req_o, .call_vec_o, .call_rank_o, .call_ack_i,
    .struct2_mode_o);

// *** sim/ipv_core_model.sv ***
// Behavioural core: machine cycles, returns and call acknowledge
`timescale 1ns/100ps
module ipv_core_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench control
    input wire logic [2:0] ilen_i,
    input wire logic do_return_from_interrupt_i,
    // Call handshake
    input wire logic call_req_i,
    input wire logic [3:0] call_rank_i,
    output logic call_ack_o,
    output logic [3:0] ack_rank_o,
    // Timing
    output logic mc_phase2_o,
    output logic last_cycle_o,
    output logic return_from_interrupt_o
);
    logic [1:0] ph_reg;
    logic [2:0] mc_reg;
    assign mc_phase2_o = ph_reg == 2'h1;
    assign last_cycle_o = mc_reg + 3'h1 >= ilen_i;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_reg <= 2'h0;
            mc_reg <= 3'h0;
            return_from_interrupt_o <= 1'b0;
            call_ack_o <= 1'b0;
            ack_rank_o <= 4'h0;
        end else begin
            ph_reg <= ph_reg + 2'h1;
            call_ack_o <= call_req_i && !call_ack_o && ph_reg == 2'h2;
            ack_rank_o <= call_rank_i;
            if (mc_phase2_o) begin
                mc_reg <= last_cycle_o ? 3'h0 : mc_reg + 3'h1;
                if (last_cycle_o) begin
                    return_from_interrupt_o <= do_return_from_interrupt_i;
                end
            end
        end
    end
endmodule : ipv_core_model

// *** sim/ipv_top_bench.sv ***
// Self-checking testbench for the interrupt prioritizer
`timescale 1ns/100ps
module ipv_top_bench;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, do_return_from_interrupt = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic [13:0] node_event_i = 14'h0;
    logic [13:0] node_flags = 14'h0;
    logic ce = 1'b1;
    logic [4:0] nm_event_i = 5'h0;
    logic [2:0] ilen = 3'h1;
    logic [15:0] call_vec_o;
    logic [3:0] call_rank_o, ack_rank_i;
    logic ack_o, mc_phase2_i, last_cycle_i, return_from_interrupt_i, call_req_o, call_ack_i, struct2_mode_o;
    int error_cnt = 0, cmp_count = 0, cyc_cnt = 0;
    always #50 clk_i = ~clk_i;
    ipv_top ipv_top_i (.clk_i, .rst_i, .ce_i(ce), .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i, .dat_o,
        .ack_o, .node_event_i, .node_flags_i(node_flags), .nm_event_i, .nm_flags_i(5'h0), .mc_phase2_i, .last_cycle_i,
        .return_from_interrupt_i, .call_req_o, .call_vec_o, .call_rank_o, .call_ack_i, .ack_rank_i, .struct2_mode_o,
        .sfr_page_select_o());
    ipv_core_model ipv_core_model_i (.clk_i, .rst_i, .ilen_i(ilen), .do_return_from_interrupt_i(do_return_from_interrupt), .call_req_i(call_req_o),
        .call_rank_i(call_rank_o), .call_ack_o(call_ack_i), .ack_rank_o(ack_rank_i), .mc_phase2_o(mc_phase2_i),
        .last_cycle_o(last_cycle_i), .return_from_interrupt_o(return_from_interrupt_i));
    ////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        repeat (20) if (ack_o !== 1'b1) @(posedge clk_i);
        chk("bus ack", 16'h1, {15'h0, ack_o});
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk("register read", {8'h0, e}, {8'h0, q});
    endtask : rd
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task pulse(input logic [13:0] n, input logic [4:0] m);
        @(posedge clk_i);
        node_event_i <= n;
        nm_event_i <= m;
        @(posedge clk_i);
        node_event_i <= 14'h0;
        nm_event_i <= 5'h0;
    endtask : pulse
    task wait_call(input logic [15:0] v, input logic [3:0] r);
        repeat (36) if (call_req_o !== 1'b1) @(posedge clk_i);
        chk("call vector", v, call_vec_o);
        chk("call rank", {12'h0, r}, {12'h0, call_rank_o});
        repeat (8) if (call_req_o === 1'b1) @(posedge clk_i);
        chk("call taken", 16'h0, {15'h0, call_req_o});
    endtask : wait_call
    task no_call(input int c);
        logic seen;
        seen = 1'b0;
        repeat (c) begin
            @(posedge clk_i);
            if (call_req_o !== 1'b0) seen = 1'b1;
        end
        chk("call absent", 16'h0, {15'h0, seen});
    endtask : no_call
    task ret_int;
        do_return_from_interrupt <= 1'b1;
        repeat (40) if (return_from_interrupt_i !== 1'b1) @(posedge clk_i);
        do_return_from_interrupt <= 1'b0;
        repeat (40) if (return_from_interrupt_i !== 1'b0) @(posedge clk_i);
    endtask : ret_int
    ////////////////////////////////////////////////////////////////////////
    task t_regs;
        rd(8'h00, 8'h04);
        rd(8'h04, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h0C, 8'h00);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h15);
        chk("mode output", 16'h1, {15'h0, struct2_mode_o});
        wr(8'h00, 8'h04);
        wr(8'h04, 8'hFF);
        rd(8'h04, 8'hBF);
        wr(8'h08, 8'hA5);
        rd(8'h08, 8'hA5);
        wr(8'h0C, 8'hFF);
        rd(8'h0C, 8'h67);
        rd(8'h40, 8'h00);
        $display("test regs done");
    endtask : t_regs
    task t_vectors;
        wr(8'h08, 8'hFF);
        for (int k = 0; k < 14; k++) begin
            pulse(14'h1 << k, 5'h0);
            wait_call(16'h0003 + 16'(k * 8), 4'(k + 1));
            ret_int();
        end
        for (int s = 0; s < 5; s++) begin
            pulse(14'h0, 5'h1 << s);
            wait_call(16'h0073, 4'h0);
            ret_int();
        end
        $display("test vectors done");
    endtask : t_vectors
    task t_mask;
        wr(8'h04, 8'h3F);
        pulse(14'h1, 5'h0);
        no_call(40);
        pulse(14'h0, 5'h10);
        wait_call(16'h0073, 4'h0);
        ret_int();
        wr(8'h04, 8'hBF);
        wait_call(16'h0003, 4'h1);
        ret_int();
        $display("test mask done");
    endtask : t_mask
    task t_prio;
        ilen <= 3'h3;
        wr(8'h10, 8'h20);
        pulse(14'h28, 5'h0);
        wait_call(16'h002B, 4'h6);
        no_call(40);
        ret_int();
        wait_call(16'h001B, 4'h4);
        pulse(14'h20, 5'h0);
        wait_call(16'h002B, 4'h6);
        ret_int();
        ret_int();
        pulse(14'h06, 5'h0);
        wait_call(16'h000B, 4'h2);
        ret_int();
        wait_call(16'h0013, 4'h3);
        ret_int();
        $display("test priority done");
    endtask : t_prio
    task t_mode;
        node_flags <= 14'h1;
        wr(8'h00, 8'h14);
        wr(8'h04, 8'h80);
        pulse(14'h1, 5'h0);
        no_call(20);
        wr(8'h04, 8'h81);
        wait_call(16'h0003, 4'h1);
        ret_int();
        wr(8'h04, 8'h80);
        pulse(14'h1, 5'h0);
        node_flags <= 14'h0;
        @(posedge clk_i);
        node_flags <= 14'h1;
        wr(8'h04, 8'h81);
        no_call(40);
        wr(8'h00, 8'h04);
        wr(8'h04, 8'h01);
        pulse(14'h1, 5'h0);
        wr(8'h04, 8'h00);
        wr(8'h04, 8'h81);
        no_call(40);
        ce <= 1'b0;
        pulse(14'h1, 5'h0);
        ce <= 1'b1;
        no_call(40);
        node_flags <= 14'h0;
        $display("test mode done");
    endtask : t_mode
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_vectors();
        t_mask();
        t_prio();
        t_mode();
        close_out();
    end
endmodule : ipv_top_bench
